// File: design/usfl_pkg.sv
// Package for the serial port control and status block.
// Assumes AXI4-Lite register access with 32-bit aligned words.
package usfl_pkg;
   // Register byte offsets
   localparam logic [3:0] OFS_INT_SOURCE    = 4'h0;
   localparam logic [3:0] OFS_QUEUE_CONTROL = 4'h4;
   localparam logic [3:0] OFS_LINE_FORMAT   = 4'h8;
   localparam logic [3:0] OFS_MODEM_CONTROL = 4'hC;
   localparam int         ADDR_W            = 4;

   // Queue control fields
   localparam int QC_ENABLE   = 0;
   localparam int QC_RX_RESET = 1;
   localparam int QC_TX_RESET = 2;
   localparam int QC_TX_TRIG  = 4;
   localparam int QC_RX_TRIG  = 6;

   // Line format fields
   localparam int LF_LEN     = 0;
   localparam int LF_STOP    = 2;
   localparam int LF_PAR_EN  = 3;
   localparam int LF_PAR_EVN = 4;
   localparam int LF_PAR_FRC = 5;
   localparam int LF_BREAK   = 6;
   localparam int LF_DIVSEL  = 7;

   // Modem control fields
   localparam int MC_DTR = 0;
   localparam int MC_RTS = 1;

   // Enhanced feature register fields
   localparam int EF_ENH      = 4;
   localparam int EF_AUTO_RTS = 6;

   // Reset values
   localparam logic [7:0] LINE_FORMAT_RST   = 8'h00;
   localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
   localparam logic [1:0] TRIG_RST          = 2'h0;

   // Interrupt codes, bits 5:0
   localparam logic [5:0] IC_LINE_STATUS = 6'h06;
   localparam logic [5:0] IC_RX_TIMEOUT  = 6'h0C;
   localparam logic [5:0] IC_RX_READY    = 6'h04;
   localparam logic [5:0] IC_TX_READY    = 6'h02;
   localparam logic [5:0] IC_MODEM       = 6'h00;
   localparam logic [5:0] IC_XOFF        = 6'h10;
   localparam logic [5:0] IC_FLOW_PIN    = 6'h20;
   localparam logic [5:0] IC_NONE        = 6'h01;

   localparam logic [4:0] QUEUE_DEPTH = 5'h10;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: design/usfl_ctrl.sv
// Control and status logic of a serial port with 16-byte queues.
// Assumes AXI4-Lite master; serial shifters and queues are outside.
// Summary of operation
// - Source bit 0 reads 0 while interrupt pending, 1 when none or wake-up.
// - Source read returns highest of seven priorities; lower ones remain queued.
// - Source bits 5 and 4 active only with enhanced enable set.
// - Bit 4 sets on Xoff match, stays until Xon received.
// - Bit 5 indicates clear-to-send or request-to-send changed state.
// - Bits 7:6 read 1 with queues enabled, 0 when disabled.
// - Queue control write-only; bit 0 must be set for other bits.
// - Bit 1 with bit 0 resets receive pointers, then self-clears.
// - Bit 2 with bit 0 resets transmit pointers, then self-clears.
// - Bits 5:4 select transmit trigger 1,4,8,14; enhanced enable needed.
// - Transmit interrupt when count below trigger or empties after low reload.
// - Bits 7:6 select receive trigger 1,4,8,14; interrupt on crossing.
// - Line format bits 1:0 select 5 to 8 bit characters.
// - Bit 2 gives one stop, or 1.5 for 5-bit, else two.
// - Bit 3 enables parity generation and checking.
// - Bit 4 selects odd at 0, even at 1.
// - With bit 5, parity forced 1 when bit 4 is 0, else 0.
// - Bit 6 holds transmit output at space until cleared.
// - Bit 7 selects divisor latches instead of data registers.
// - Modem bits 0,1 drive terminal-ready and request-to-send inverted.
// - Automatic flow control may drive request-to-send when enabled.
`timescale 1ns/10ps
`default_nettype none
module usfl_ctrl (
   input  wire  logic        aclk,
   input  wire  logic        aresetn,
   input  wire  logic [3:0]  s_axi_awaddr,
   input  wire  logic        s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   input  wire  logic        s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   input  wire  logic [3:0]  s_axi_araddr,
   input  wire  logic        s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire  logic        s_axi_rready,
   input  wire  logic [7:0]  enhanced_feature_reg,
   input  wire  logic        line_status_event,
   input  wire  logic        rx_timeout_event,
   input  wire  logic        modem_status_event,
   input  wire  logic        xoff_match,
   input  wire  logic        xon_match,
   input  wire  logic        cts_change,
   input  wire  logic        wake_event,
   input  wire  logic        auto_rts_level,
   input  wire  logic [4:0]  rx_count,
   input  wire  logic [4:0]  tx_count,
   input  wire  logic        tx_reload,
   input  wire  logic        tx_data_in,
   output logic              tx_out,
   output logic              queues_enabled,
   output logic              rx_queue_reset,
   output logic              tx_queue_reset,
   output logic [3:0]        char_bits,
   output logic              stop_two,
   output logic              stop_half,
   output logic              parity_en,
   output logic              parity_forced,
   output logic              parity_even,
   output logic              parity_force_val,
   output logic              divisor_select,
   output logic              dtr_n,
   output logic              rts_n,
   output logic              irq_pending
);

   typedef struct packed {
      logic        aw_full;
      logic [3:0]  aw_addr;
      logic        w_full;
      logic [7:0]  w_data;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        q_en;
      logic [1:0]  tx_trig;
      logic [1:0]  rx_trig;
      logic        rx_rst;
      logic        tx_rst;
      logic [7:0]  line_format;
      logic [7:0]  modem_control;
      logic        xoff_flag;
      logic        pin_flag;
      logic        tx_flag;
      logic        tx_low_reload;
      logic        wake_flag;
      logic        rts_prev;
      logic        tx_out;
   } usfl_state_s;

   usfl_state_s st_r;
   usfl_state_s st_nxt;

   function automatic logic [4:0] usfl_trig_level(input logic [1:0] code);
      case (code)
         2'h0: begin
            usfl_trig_level = 5'h01;
         end
         2'h1: begin
            usfl_trig_level = 5'h04;
         end
         2'h2: begin
            usfl_trig_level = 5'h08;
         end
         default: begin
            usfl_trig_level = 5'h0E;
         end
      endcase
   endfunction

   logic       enh;
   logic       rts_level;
   logic       rx_ready;
   logic [5:0] code;
   logic       do_write;
   logic       do_read;
   logic       rd_source;

   always_comb begin
      enh = enhanced_feature_reg[usfl_pkg::EF_ENH];

      if (enhanced_feature_reg[usfl_pkg::EF_AUTO_RTS]) begin
         rts_level = auto_rts_level;
      end else begin
         rts_level = ~st_r.modem_control[usfl_pkg::MC_RTS];
      end

      rx_ready = st_r.q_en && (rx_count >= usfl_trig_level(st_r.rx_trig));

      if (line_status_event) begin
         code = usfl_pkg::IC_LINE_STATUS;
      end else if (rx_timeout_event) begin
         code = usfl_pkg::IC_RX_TIMEOUT;
      end else if (rx_ready) begin
         code = usfl_pkg::IC_RX_READY;
      end else if (st_r.tx_flag) begin
         code = usfl_pkg::IC_TX_READY;
      end else if (modem_status_event) begin
         code = usfl_pkg::IC_MODEM;
      end else if (enh && st_r.xoff_flag) begin
         code = usfl_pkg::IC_XOFF;
      end else if (enh && st_r.pin_flag) begin
         code = usfl_pkg::IC_FLOW_PIN;
      end else begin
         code = usfl_pkg::IC_NONE;
      end
   end

   assign do_write  = st_r.aw_full && st_r.w_full && !st_r.bvalid;
   assign do_read   = s_axi_arvalid && !st_r.rvalid;
   assign rd_source = do_read && (s_axi_araddr == usfl_pkg::OFS_INT_SOURCE);

   always_comb begin
      st_nxt        = st_r;
      // Reset pulses last one clock unless rewritten
      st_nxt.rx_rst = 1'b0;
      st_nxt.tx_rst = 1'b0;
      if (s_axi_awvalid && !st_r.aw_full) begin
         st_nxt.aw_full = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end

      if (s_axi_wvalid && !st_r.w_full) begin
         st_nxt.w_full = 1'b1;
         // Only the low byte lane is kept
         st_nxt.w_data = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end

      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end

      if (do_write) begin
         st_nxt.aw_full = 1'b0;
         st_nxt.w_full  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = usfl_pkg::RESP_OKAY;
         case (st_r.aw_addr)
            usfl_pkg::OFS_QUEUE_CONTROL: begin
               st_nxt.q_en = st_r.w_data[usfl_pkg::QC_ENABLE];
               if (st_r.w_data[usfl_pkg::QC_ENABLE]) begin
                  st_nxt.rx_rst = st_r.w_data[usfl_pkg::QC_RX_RESET];
                  st_nxt.tx_rst = st_r.w_data[usfl_pkg::QC_TX_RESET];
                  st_nxt.rx_trig = st_r.w_data[usfl_pkg::QC_RX_TRIG +: 2];
                  if (enh) begin
                     st_nxt.tx_trig = st_r.w_data[usfl_pkg::QC_TX_TRIG +: 2];
                  end
               end
            end
            usfl_pkg::OFS_LINE_FORMAT: begin
               st_nxt.line_format = st_r.w_data;
            end
            usfl_pkg::OFS_MODEM_CONTROL: begin
               st_nxt.modem_control = st_r.w_data;
            end
            // Read-only register: write accepted and dropped
            usfl_pkg::OFS_INT_SOURCE: begin
               st_nxt.bresp = usfl_pkg::RESP_OKAY;
            end
            default: begin
               st_nxt.bresp = usfl_pkg::RESP_SLVERR;
            end
         endcase
      end

      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end

      if (do_read) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = usfl_pkg::RESP_OKAY;
         st_nxt.rdata  = 32'h0000_0000;
         case (s_axi_araddr)
            usfl_pkg::OFS_INT_SOURCE: begin
               st_nxt.rdata[7:0] = {st_r.q_en, st_r.q_en, code};
            end
            // Write-only register reads as zero
            usfl_pkg::OFS_QUEUE_CONTROL: begin
               st_nxt.rdata = 32'h0000_0000;
            end
            usfl_pkg::OFS_LINE_FORMAT: begin
               st_nxt.rdata[7:0] = st_r.line_format;
            end
            usfl_pkg::OFS_MODEM_CONTROL: begin
               st_nxt.rdata[7:0] = st_r.modem_control;
            end
            default: begin
               st_nxt.rresp = usfl_pkg::RESP_SLVERR;
            end
         endcase
      end

      if (tx_reload) begin
         st_nxt.tx_low_reload = (tx_count <= usfl_trig_level(st_r.tx_trig));
      end

      // transmit ready flag; a source read clears it, new event wins
      if (rd_source && code == usfl_pkg::IC_TX_READY) begin
         st_nxt.tx_flag = 1'b0;
      end
      if (tx_reload) begin
         st_nxt.tx_flag = 1'b0;
      end
      // Reload has priority so a refill is not flagged at once
      if (st_r.q_en && !tx_reload) begin
         if (tx_count < usfl_trig_level(st_r.tx_trig) && !st_r.tx_low_reload) begin
            st_nxt.tx_flag = 1'b1;
         end
         if (tx_count == 5'h00 && st_r.tx_low_reload) begin
            st_nxt.tx_flag       = 1'b1;
            st_nxt.tx_low_reload = 1'b0;
         end
      end

      if (xon_match) begin
         st_nxt.xoff_flag = 1'b0;
      end
      if (xoff_match) begin
         st_nxt.xoff_flag = 1'b1;
      end

      // pin change flag; read of source clears it, set wins
      st_nxt.rts_prev = rts_level;
      if (rd_source && code == usfl_pkg::IC_FLOW_PIN) begin
         st_nxt.pin_flag = 1'b0;
      end
      if (cts_change || (rts_level != st_r.rts_prev)) begin
         st_nxt.pin_flag = 1'b1;
      end

      // Wake-up shows as no pending, so its flag gives no code
      if (rd_source) begin
         st_nxt.wake_flag = 1'b0;
      end
      if (wake_event) begin
         st_nxt.wake_flag = 1'b1;
      end

      if (st_r.line_format[usfl_pkg::LF_BREAK]) begin
         st_nxt.tx_out = 1'b0;
      end else begin
         st_nxt.tx_out = tx_data_in;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r               <= '0;
         st_r.tx_trig       <= usfl_pkg::TRIG_RST;
         st_r.rx_trig       <= usfl_pkg::TRIG_RST;
         st_r.line_format   <= usfl_pkg::LINE_FORMAT_RST;
         st_r.modem_control <= usfl_pkg::MODEM_CONTROL_RST;
         // Pin idle level, so no false change after reset
         st_r.rts_prev      <= 1'b1;
         st_r.tx_out        <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Handshake outputs come from registered state only; one write and one read in flight
   assign s_axi_awready = !st_r.aw_full;
   assign s_axi_wready  = !st_r.w_full;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rdata   = st_r.rdata;
   assign s_axi_rresp   = st_r.rresp;

   assign queues_enabled = st_r.q_en;

   assign rx_queue_reset = st_r.rx_rst;
   assign tx_queue_reset = st_r.tx_rst;

   assign char_bits = 4'h5 + {2'h0, st_r.line_format[usfl_pkg::LF_LEN +: 2]};

   assign stop_two  = st_r.line_format[usfl_pkg::LF_STOP] && (st_r.line_format[1:0] != 2'h0);
   assign stop_half = st_r.line_format[usfl_pkg::LF_STOP] && (st_r.line_format[1:0] == 2'h0);

   assign parity_en = st_r.line_format[usfl_pkg::LF_PAR_EN];

   assign parity_even = st_r.line_format[usfl_pkg::LF_PAR_EVN];

   assign parity_forced    = st_r.line_format[usfl_pkg::LF_PAR_FRC];
   assign parity_force_val = ~st_r.line_format[usfl_pkg::LF_PAR_EVN];

   assign divisor_select = st_r.line_format[usfl_pkg::LF_DIVSEL];

   assign dtr_n   = ~st_r.modem_control[usfl_pkg::MC_DTR];
   assign rts_n   = rts_level;
   assign tx_out  = st_r.tx_out;
   assign irq_pending = (code != usfl_pkg::IC_NONE);

endmodule
`default_nettype wire

// File: tb/usfl_ctrl_monitor.sv
// Assertions on the ports of the serial port control block.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/10ps
`default_nettype none
module usfl_ctrl_monitor (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_bvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic [7:0]  enhanced_feature_reg,
   input wire logic        auto_rts_level,
   input wire logic        tx_data_in,
   input wire logic        tx_out,
   input wire logic        queues_enabled,
   input wire logic        rx_queue_reset,
   input wire logic        tx_queue_reset,
   input wire logic [3:0]  char_bits,
   input wire logic        stop_half,
   input wire logic        rts_n,
   input wire logic        irq_pending
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Source register read just answered
   sequence src_read;
      $rose(s_axi_rvalid) && $past(s_axi_araddr) == 4'h0;
   endsequence
   a_pend_bit:
      assert property (src_read |-> s_axi_rdata[0] == !$past(irq_pending)) else $error("pending bit wrong");
   a_enh_hidden:
      assert property (src_read ##0 !$past(enhanced_feature_reg[4]) |-> s_axi_rdata[5:4] == 2'h0)
      else $error("bits 5:4 shown");
   a_fifo_bits:
      assert property (src_read |-> s_axi_rdata[7:6] == {2{$past(queues_enabled)}}) else $error("bits 7:6 wrong");
   a_rx_pulse:
      assert property (rx_queue_reset |-> $rose(s_axi_bvalid) && queues_enabled ##1 !rx_queue_reset)
      else $error("rx queue reset pulse wrong");
   a_tx_pulse:
      assert property (tx_queue_reset |-> $rose(s_axi_bvalid) && queues_enabled ##1 !tx_queue_reset)
      else $error("tx queue reset pulse wrong");
   a_char_range:
      assert property (char_bits >= 4'h5 && char_bits <= 4'h8) else $error("char length out of range");
   a_stop_half:
      assert property (stop_half |-> char_bits == 4'h5) else $error("half stop without 5 bits");
   a_tx_pass:
      assert property ($past(aresetn) && tx_out |-> $past(tx_data_in)) else $error("tx high without data");
   a_auto_rts:
      assert property (enhanced_feature_reg[6] |-> rts_n == auto_rts_level) else $error("auto rts not followed");
   c_rx_reset: cover property (rx_queue_reset);
   c_enh_read: cover property (src_read ##0 enhanced_feature_reg[4]);
   c_break: cover property (!tx_out && tx_data_in);
endmodule
bind usfl_ctrl usfl_ctrl_monitor usfl_ctrl_monitor_inst (
   .aclk, .aresetn, .s_axi_araddr, .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid, .enhanced_feature_reg,
   .auto_rts_level, .tx_data_in, .tx_out, .queues_enabled, .rx_queue_reset, .tx_queue_reset, .char_bits,
   .stop_half, .rts_n, .irq_pending
);
`default_nettype wire

// File: tb/usfl_host.sv
// Host model: AXI4-Lite master with blocking write and read tasks.
// Assumes the bench calls one task at a time, after reset.
`timescale 1ns/10ps
`default_nettype none
module usfl_host (
   input  wire logic        aclk,
   output var  logic [3:0]  s_axi_awaddr,
   output var  logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output var  logic [31:0] s_axi_wdata,
   output var  logic [3:0]  s_axi_wstrb,
   output var  logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output var  logic        s_axi_bready,
   output var  logic [3:0]  s_axi_araddr,
   output var  logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output var  logic        s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb/usfl_ctrl_test.sv
// Self-checking bench for the serial port control block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module usfl_ctrl_test;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, char_bits;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0]  enhanced_feature_reg, rd_v;
   logic        line_status_event, rx_timeout_event, modem_status_event, xoff_match, xon_match, cts_change;
   logic        auto_rts_level, tx_data_in, tx_out, queues_enabled, rx_queue_reset, tx_queue_reset;
   logic        stop_two, stop_half, parity_en, parity_forced, parity_even, parity_force_val;
   logic        divisor_select, dtr_n, rts_n, irq_pending;
   int          err_total, n_compared, cyc, n_rxr, n_txr;
   logic [7:0]  lf [12] = '{8'h00, 8'h05, 8'h0A, 8'h0F, 8'h04, 8'h07, 8'h08, 8'h18, 8'h28, 8'h38, 8'h40, 8'h80};
   logic [2:0]  pr [4] = '{3'h1, 3'h3, 3'h7, 3'h0};
   logic [5:0]  pe [4] = '{usfl_pkg::IC_MODEM, usfl_pkg::IC_RX_TIMEOUT, usfl_pkg::IC_LINE_STATUS, usfl_pkg::IC_NONE};
   usfl_ctrl usfl_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .enhanced_feature_reg, .line_status_event, .rx_timeout_event, .modem_status_event, .xoff_match,
      .xon_match, .cts_change, .wake_event(1'b0), .auto_rts_level, .rx_count(5'h00), .tx_count(5'h10),
      .tx_reload(1'b0), .tx_data_in, .tx_out, .queues_enabled, .rx_queue_reset, .tx_queue_reset, .char_bits,
      .stop_two, .stop_half, .parity_en, .parity_forced, .parity_even, .parity_force_val, .divisor_select,
      .dtr_n, .rts_n, .irq_pending);
   usfl_host usfl_host_inst (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task automatic wrap_up;
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Toggling serial data, pulse counters, hang limit
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      tx_data_in <= ~tx_data_in;
      if (rx_queue_reset === 1'b1) n_rxr <= n_rxr + 1;
      if (tx_queue_reset === 1'b1) n_txr <= n_txr + 1;
      if (cyc == 5000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      usfl_host_inst.wr(a, d, rsp);
      `CHK(rsp, usfl_pkg::RESP_OKAY)
   endtask
   task automatic rreg(input logic [3:0] a, input logic [7:0] e);
      usfl_host_inst.rd(a, rd_v, rsp);
      `CHK(rd_v, e)
   endtask
   task automatic pulse(input logic [2:0] k);
      @(posedge aclk) {cts_change, xon_match, xoff_match} <= k;
      @(posedge aclk) {cts_change, xon_match, xoff_match} <= 3'h0;
   endtask
   initial begin
      {err_total, n_compared, cyc, n_rxr, n_txr} = '0;
      aresetn = 1'b0;
      enhanced_feature_reg = 8'h00;
      {line_status_event, rx_timeout_event, modem_status_event, cts_change, xon_match, xoff_match} = '0;
      auto_rts_level = 1'b1;
      tx_data_in = 1'b1;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rreg(4'h0, 8'h01);
      rreg(4'h8, usfl_pkg::LINE_FORMAT_RST);
      rreg(4'hC, usfl_pkg::MODEM_CONTROL_RST);
      `CHK({dtr_n, rts_n, char_bits}, 6'h35)
      usfl_host_inst.rd(4'h2, rd_v, rsp);
      `CHK(rsp, usfl_pkg::RESP_SLVERR)
      foreach (lf[i]) begin
         wreg(4'h8, lf[i]);
         rreg(4'h8, lf[i]);
         `CHK(char_bits, 4'h5 + {2'h0, lf[i][1:0]})
         `CHK(stop_half, lf[i][2] && lf[i][1:0] == 2'h0)
         `CHK(stop_two, lf[i][2] && lf[i][1:0] != 2'h0)
         `CHK(parity_en, lf[i][3])
         `CHK(parity_forced, lf[i][5])
         if (lf[i][3] && !lf[i][5]) `CHK(parity_even, lf[i][4])
         if (lf[i][3] && lf[i][5]) `CHK(parity_force_val, !lf[i][4])
         `CHK(divisor_select, lf[i][7])
         if (lf[i][6]) `CHK(tx_out, 1'b0)
      end
      for (int m = 0; m < 4; m++) begin
         wreg(4'hC, m[7:0]);
         rreg(4'hC, m[7:0]);
         `CHK({dtr_n, rts_n}, {!m[0], !m[1]})
      end
      enhanced_feature_reg <= 8'h40;
      for (int k = 0; k < 2; k++) begin
         @(posedge aclk) auto_rts_level <= k[0];
         @(posedge aclk) `CHK(rts_n, k[0])
      end
      enhanced_feature_reg <= 8'h00;
      wreg(4'h4, 8'h07);
      rreg(4'h4, 8'h00);
      rreg(4'h0, 8'hC1);
      wreg(4'h4, 8'h06);
      `CHK(queues_enabled, 1'b0)
      rreg(4'h0, 8'h01);
      wreg(4'h4, 8'h03);
      repeat (2) @(posedge aclk);
      `CHK({n_rxr, n_txr}, {32'd2, 32'd1})
      pulse(3'h1);
      rreg(4'h0, 8'hC1);
      pulse(3'h2);
      enhanced_feature_reg <= 8'h10;
      pulse(3'h1);
      rreg(4'h0, 8'hD0);
      rreg(4'h0, 8'hD0);
      pulse(3'h2);
      rreg(4'h0, 8'hE0);
      pulse(3'h4);
      rreg(4'h0, 8'hE0);
      rreg(4'h0, 8'hC1);
      foreach (pr[i]) begin
         @(posedge aclk) {line_status_event, rx_timeout_event, modem_status_event} <= pr[i];
         rreg(4'h0, {2'h3, pe[i]});
         `CHK(irq_pending, pr[i] != 3'h0)
      end
      wrap_up();
   end
endmodule
`default_nettype wire
